// >>> csf_pkg.sv
// constants for the can status, interrupt and filter control block
// assumes a plain register port with one-cycle read latency
//
// Overview of operation
// - rx passive flag sets at count 128..255, not bus-off
// - tx passive flag sets at count 128..255, not bus-off
// - bus-off flag sets when tx count exceeds 255
// - bus-off clear refused until 128 recessive idles
// - rx warning at 96..127 only without passive/bus-off
// - tx warning at 96..127 only without passive/bus-off
// - overrun event sets overrun flag, error interrupt
// - rx full blocks swaps until software clears it
// - soft reset holds four registers at reset values
// - enables route flags to wakeup, receive, error interrupts
// - empty flags write-one-clear, abort acks read only
// - empty flag sets on send or abort success
// - clearing empty flag also clears abort ack
// - empty flag set clears abort request; zero ignored
// - abort granted only if not started or failed
// - filter mode selects 32/16/8-bit filters or closed
// - hit index updates on each foreground swap
// - filter control writable only during soft reset
// - per-buffer enable gates empty flag onto transmit interrupt
// - rx flags write-one-clear only after cause gone
// - bus activity in sleep sets wakeup flag
package csf_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_RX_FLAG = 8'h04;
    localparam logic [7:0] ADDR_RX_IRQ_EN = 8'h05;
    localparam logic [7:0] ADDR_TX_FLAG = 8'h06;
    localparam logic [7:0] ADDR_TX_CTRL = 8'h07;
    localparam logic [7:0] ADDR_FILTER = 8'h08;
    localparam logic [7:0] ADDR_MODULE_CTL = 8'h00;
    // ----------------------------------------------------------------
    // rx flag bit positions (enables use the same positions)
    // ----------------------------------------------------------------
    localparam int BIT_WAKEUP = 7;
    localparam int BIT_RX_WARN = 6;
    localparam int BIT_TX_WARN = 5;
    localparam int BIT_RX_PASS = 4;
    localparam int BIT_TX_PASS = 3;
    localparam int BIT_BUS_OFF = 2;
    localparam int BIT_OVERRUN = 1;
    localparam int BIT_RX_FULL = 0;
    localparam int BIT_SOFT_RESET = 0;
    // tx flag: abort ack in [6:4], empty in [2:0]; tx ctrl likewise
    localparam int POS_ABORT = 4;
    localparam int POS_EMPTY = 0;
    localparam int NUM_TX_BUF = 3;
    // filter register: mode in [5:4], hit in [2:0]
    localparam int POS_MODE = 4;
    localparam int POS_HIT = 0;
    // ----------------------------------------------------------------
    // reset values and thresholds
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_RX_FLAG = 8'h00;
    localparam logic [7:0] RST_RX_IRQ_EN = 8'h00;
    localparam logic [2:0] RST_TX_EMPTY = 3'h7;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [8:0] ERR_WARN_MIN = 9'h060;
    localparam logic [8:0] ERR_PASS_MIN = 9'h080;
    localparam logic [8:0] ERR_BUS_OFF_MIN = 9'h100;
    localparam logic [7:0] RECOVERY_IDLES = 8'h80;
    localparam logic [1:0] MODE_CLOSED = 2'h3;
endpackage

// >>> csf_status_ctrl.sv
// status flags, interrupt enables, abort handshake and filter control
// protocol engine supplies counts and one-cycle event pulses
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ns
module csf_status_ctrl
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // error counters, 9 bits so bus-off (above 255) is visible
    input wire logic [8:0] rx_err_count,
    input wire logic [8:0] tx_err_count,
    input wire logic idle_seq_pulse,
    input wire logic overrun_pulse,
    input wire logic sleep_mode,
    input wire logic bus_activity,
    input wire logic rx_msg_ready,
    input wire logic [2:0] rx_hit_index,
    input wire logic [2:0] tx_sent_pulse,
    input wire logic [2:0] tx_in_progress,
    output logic swap_grant,
    output logic [2:0] abort_request,
    output logic [1:0] filter_mode,
    output logic soft_reset_ctl,
    output logic wakeup_irq,
    output logic rx_irq,
    output logic err_irq,
    output logic tx_irq
);
    import csf_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] rx_flag; // receiver flags
    logic [7:0] rx_en; // receiver interrupt enables
    logic [2:0] tx_empty; // buffer empty flags
    logic [2:0] abort_ack; // abort acknowledge flags
    logic [2:0] tx_empty_en; // transmit empty enables
    logic [2:0] filter_hit_index; // hit of foreground message
    logic [7:0] idle_count; // recessive idle sequences since bus-off
    logic [7:0] next_rx_flag;
    logic [2:0] next_tx_empty;
    logic [2:0] abort_grant;
    logic [2:0] empty_clear;
    logic [7:0] rx_clear;
    logic [7:0] rx_set;
    logic [7:0] rx_cond;
    logic swap_now;

    // range test used for both counters
    function automatic logic in_range(input logic [8:0] v, input logic [8:0] lo,
                                      input logic [8:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ----------------------------------------------------------------
    // set conditions
    // ----------------------------------------------------------------
    // level causes; flags stay live while these hold
    always_comb
    begin
        rx_cond = 8'h00;
        rx_cond[BIT_BUS_OFF] = tx_err_count >= ERR_BUS_OFF_MIN;
        rx_cond[BIT_RX_PASS] = in_range(rx_err_count, ERR_PASS_MIN, 9'h0ff)
                               && !rx_flag[BIT_BUS_OFF];
        rx_cond[BIT_TX_PASS] = in_range(tx_err_count, ERR_PASS_MIN, 9'h0ff)
                               && !rx_flag[BIT_BUS_OFF];
        rx_cond[BIT_RX_WARN] = in_range(rx_err_count, ERR_WARN_MIN, 9'h07f)
                               && !rx_flag[BIT_RX_PASS] && !rx_flag[BIT_TX_PASS]
                               && !rx_flag[BIT_BUS_OFF];
        rx_cond[BIT_TX_WARN] = in_range(tx_err_count, ERR_WARN_MIN, 9'h07f)
                               && !rx_flag[BIT_RX_PASS] && !rx_flag[BIT_TX_PASS]
                               && !rx_flag[BIT_BUS_OFF];
    end

    // swap only when a message waits, buffer free and filter open
    assign swap_now = rx_msg_ready && !rx_flag[BIT_RX_FULL]
                      && (filter_mode != MODE_CLOSED) && !soft_reset_ctl;

    always_comb
    begin
        rx_set = rx_cond;
        rx_set[BIT_OVERRUN] = overrun_pulse;
        rx_set[BIT_RX_FULL] = swap_now;
        rx_set[BIT_WAKEUP] = sleep_mode && bus_activity;
        // clear by one, but only once the cause has gone
        rx_clear = (wr && addr == ADDR_RX_FLAG) ? wdata & ~rx_cond : 8'h00;
        // bus-off held until enough recessive idle sequences seen
        if (idle_count < RECOVERY_IDLES)
        begin
            rx_clear[BIT_BUS_OFF] = 1'b0;
        end
        // set wins over a simultaneous clear
        next_rx_flag = (rx_flag & ~rx_clear) | rx_set;
    end

    // ----------------------------------------------------------------
    // transmit handshake
    // ----------------------------------------------------------------
    always_comb
    begin
        // abort granted only for a scheduled buffer not on the wire
        abort_grant = abort_request & ~tx_empty & ~tx_in_progress;
        empty_clear = (wr && addr == ADDR_TX_FLAG)
                      ? wdata[POS_EMPTY +: NUM_TX_BUF] : 3'h0;
        next_tx_empty = (tx_empty & ~empty_clear) | tx_sent_pulse | abort_grant;
    end

    // ----------------------------------------------------------------
    // receiver flag register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rx_flag <= RST_RX_FLAG;
        end
        else if (soft_reset_ctl)
        begin
            rx_flag <= RST_RX_FLAG;
        end
        else
        begin
            rx_flag <= next_rx_flag;
        end
    end

    // bus-off recovery counter, restarts whenever bus-off is absent
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            idle_count <= 8'h00;
        end
        else if (!rx_flag[BIT_BUS_OFF])
        begin
            idle_count <= 8'h00;
        end
        else if (idle_seq_pulse && idle_count < RECOVERY_IDLES)
        begin
            idle_count <= idle_count + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // receiver interrupt enables
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rx_en <= RST_RX_IRQ_EN;
        end
        else if (soft_reset_ctl)
        begin
            rx_en <= RST_RX_IRQ_EN;
        end
        else if (wr && addr == ADDR_RX_IRQ_EN)
        begin
            rx_en <= wdata;
        end
    end

    // ----------------------------------------------------------------
    // transmitter flags
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            tx_empty <= RST_TX_EMPTY;
            abort_ack <= 3'h0;
        end
        else if (soft_reset_ctl)
        begin
            tx_empty <= RST_TX_EMPTY;
            abort_ack <= 3'h0;
        end
        else
        begin
            tx_empty <= next_tx_empty;
            // ack set by grant; cleared with its empty flag
            abort_ack <= (abort_ack & ~empty_clear) | abort_grant;
        end
    end

    // ----------------------------------------------------------------
    // transmitter control: abort requests and empty enables
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            abort_request <= 3'h0;
            tx_empty_en <= 3'h0;
        end
        else if (soft_reset_ctl)
        begin
            abort_request <= 3'h0;
            tx_empty_en <= 3'h0;
        end
        else
        begin
            // software only sets; a buffer turning empty drops it
            if (wr && addr == ADDR_TX_CTRL)
            begin
                abort_request <= (abort_request | wdata[POS_ABORT +: NUM_TX_BUF])
                                 & ~(next_tx_empty & ~tx_empty);
                tx_empty_en <= wdata[POS_EMPTY +: NUM_TX_BUF];
            end
            else
            begin
                abort_request <= abort_request & ~(next_tx_empty & ~tx_empty);
            end
        end
    end

    // ----------------------------------------------------------------
    // soft reset control and filter configuration
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            soft_reset_ctl <= 1'b1;
        end
        else if (wr && addr == ADDR_MODULE_CTL)
        begin
            soft_reset_ctl <= wdata[BIT_SOFT_RESET];
        end
    end

    // mode only changes while filters are held off
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            filter_mode <= RST_MODE;
        end
        else if (wr && addr == ADDR_FILTER && soft_reset_ctl)
        begin
            filter_mode <= wdata[POS_MODE +: 2];
        end
    end

    // hit index tracks the foreground message
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            filter_hit_index <= 3'h0;
            swap_grant <= 1'b0;
        end
        else
        begin
            swap_grant <= swap_now;
            if (swap_now)
            begin
                filter_hit_index <= rx_hit_index;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt outputs, registered levels
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wakeup_irq <= 1'b0;
            rx_irq <= 1'b0;
            err_irq <= 1'b0;
            tx_irq <= 1'b0;
        end
        else
        begin
            wakeup_irq <= next_rx_flag[BIT_WAKEUP] && rx_en[BIT_WAKEUP]
                          && !soft_reset_ctl;
            rx_irq <= next_rx_flag[BIT_RX_FULL] && rx_en[BIT_RX_FULL]
                      && !soft_reset_ctl;
            err_irq <= |(next_rx_flag[6:1] & rx_en[6:1]) && !soft_reset_ctl;
            tx_irq <= |(next_tx_empty & tx_empty_en) && !soft_reset_ctl;
        end
    end

    // ----------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rdata <= 8'h00;
        end
        else if (rd)
        begin
            case (addr)
                ADDR_MODULE_CTL: rdata <= {7'h00, soft_reset_ctl};
                ADDR_RX_FLAG: rdata <= rx_flag;
                ADDR_RX_IRQ_EN: rdata <= rx_en;
                ADDR_TX_FLAG: rdata <= {1'b0, abort_ack, 1'b0, tx_empty};
                ADDR_TX_CTRL: rdata <= {1'b0, abort_request, 1'b0, tx_empty_en};
                ADDR_FILTER: rdata <= {2'h0, filter_mode, 1'b0, filter_hit_index};
                default: rdata <= 8'h00;
            endcase
        end
        else
        begin
            rdata <= 8'h00;
        end
    end
endmodule

// >>> csf_status_properties.sv
// checker: port-level properties of the status and control block
// bound to the block's top module; sees only its ports
`timescale 1ns/1ns
module csf_status_properties
(
    input wire logic clock,
    input wire logic reset,
    input wire logic rx_msg_ready,
    input wire logic [2:0] tx_sent_pulse,
    input wire logic [2:0] tx_in_progress,
    input wire logic swap_grant,
    input wire logic [2:0] abort_request,
    input wire logic [1:0] filter_mode,
    input wire logic soft_reset_ctl,
    input wire logic wakeup_irq,
    input wire logic rx_irq,
    input wire logic err_irq,
    input wire logic tx_irq
);
    import csf_pkg::*;
    // ----------------------------------------------------------------
    // swap, abort, filter and interrupt properties
    // ----------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // soft reset settled: every interrupt quiet
    a_soft_quiet: assert property (soft_reset_ctl && $past(soft_reset_ctl) |->
        !(wakeup_irq || rx_irq || err_irq || tx_irq)) else $error("irq during soft reset");
    a_abort_soft: assert property (soft_reset_ctl && $past(soft_reset_ctl) |->
        abort_request == 3'h0) else $error("abort request during soft reset");
    // a request on a buffer on the wire and not yet sent must stay
    a_abort_hold: assert property (!soft_reset_ctl |->
        ($past(abort_request & tx_in_progress & ~tx_sent_pulse) & ~abort_request) == 3'h0)
        else $error("abort request dropped early");
    a_closed_swap: assert property (filter_mode == MODE_CLOSED [*3] |-> !swap_grant)
        else $error("swap in closed mode");
    a_soft_swap: assert property (soft_reset_ctl [*3] |-> !swap_grant)
        else $error("swap during soft reset");
    a_swap_ready: assert property (!rx_msg_ready [*3] |-> !swap_grant)
        else $error("swap with no message");
    // full flag blocks a second swap in the very next cycle
    a_swap_single: assert property (swap_grant |=> !swap_grant)
        else $error("back to back swaps");
    a_mode_lock: assert property (!soft_reset_ctl |=> $stable(filter_mode))
        else $error("filter mode changed outside soft reset");
endmodule

// >>> csf_engine_model.sv
// protocol engine stand-in: offers received messages and send results
// assumes its tasks are called right after a rising clock edge
`timescale 1ns/1ns
module csf_engine_model
(
    input wire logic clock,
    input wire logic swap_grant,
    output logic rx_msg_ready,
    output logic [2:0] rx_hit_index,
    output logic [2:0] tx_sent_pulse
);
    // ----------------------------------------------------------------
    // message delivery and send results
    // ----------------------------------------------------------------
    initial
    begin
        rx_msg_ready = 1'b0;
        rx_hit_index = 3'h0;
        tx_sent_pulse = 3'h0;
    end
    // hold the message until swapped in, give up after a bound
    task automatic deliver(input logic [2:0] hit);
        int i;
        rx_msg_ready <= 1'b1;
        rx_hit_index <= hit;
        for (i = 0; i < 60 && swap_grant !== 1'b1; i++)
            @(negedge clock);
        @(posedge clock);
        rx_msg_ready <= 1'b0;
        // released index shows the inverse, never the stale value
        rx_hit_index <= ~hit;
    endtask
    // one-cycle success pulse for one buffer
    task automatic sent(input int idx);
        tx_sent_pulse <= 3'(1 << idx);
        @(posedge clock);
        tx_sent_pulse <= 3'h0;
        @(posedge clock);
    endtask
endmodule

// >>> csf_status_ctrl_tb.sv
// self-checking bench for the status, interrupt and filter control block
// drives register port and error inputs; engine model supplies messages
`timescale 1ns/1ns
module csf_status_ctrl_tb;
    import csf_pkg::*;
    // ----------------------------------------------------------------
    // signals, instances, helpers
    // ----------------------------------------------------------------
    logic clock, reset, wr, rd, rd_d, swap_grant, soft_reset_ctl, rx_msg_ready;
    logic idle_seq_pulse, overrun_pulse, sleep_mode, bus_activity;
    logic wakeup_irq, rx_irq, err_irq, tx_irq;
    logic [7:0] addr, wdata, rdata;
    logic [8:0] rx_err_count, tx_err_count;
    logic [2:0] rx_hit_index, tx_sent_pulse, tx_in_progress, abort_request, h1, h2;
    logic [1:0] filter_mode;
    logic [7:0] exp_q[$]; // expected read data, oldest first
    int fail_count = 0;
    int n_tests = 0;
    int m;
    csf_status_ctrl dut_u (.clock, .reset, .addr, .wdata, .wr, .rd, .rdata,
        .rx_err_count, .tx_err_count, .idle_seq_pulse, .overrun_pulse, .sleep_mode,
        .bus_activity, .rx_msg_ready, .rx_hit_index, .tx_sent_pulse, .tx_in_progress,
        .swap_grant, .abort_request, .filter_mode, .soft_reset_ctl, .wakeup_irq,
        .rx_irq, .err_irq, .tx_irq);
    csf_engine_model eng_u (.clock, .swap_grant, .rx_msg_ready, .rx_hit_index,
        .tx_sent_pulse);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one-cycle write, then a free cycle so strobes never re-assign at once
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic r(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(posedge clock);
    endtask
    // interrupt levels as {wakeup, rx, err, tx}, looked at mid-cycle
    task automatic irqs(input logic [3:0] e);
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk({4'h0, wakeup_irq, rx_irq, err_irq, tx_irq}, {4'h0, e});
        @(posedge clock);
    endtask
    always @(posedge clock)
        rd_d <= rd;
    // read data stands only in the cycle after the strobe
    always @(negedge clock)
        if (rd_d === 1'b1)
            chk(rdata, exp_q.pop_front());
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        #100000;
        fail_count++;
        close_out();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        {wr, rd, addr, wdata, rx_err_count, tx_err_count, idle_seq_pulse} = '0;
        {overrun_pulse, sleep_mode, bus_activity, tx_in_progress} = '0;
        void'($urandom(94638));
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        r(ADDR_MODULE_CTL, 8'h01);
        r(ADDR_TX_FLAG, 8'h07);
        w(ADDR_FILTER, 8'h10);
        w(ADDR_MODULE_CTL, 8'h00);
        w(ADDR_FILTER, 8'h30);
        r(ADDR_FILTER, 8'h10);
        w(ADDR_RX_IRQ_EN, 8'hff);
        r(ADDR_RX_IRQ_EN, 8'hff);
        rx_err_count <= 9'd96 + 9'($urandom % 32);
        repeat (3) @(posedge clock);
        r(ADDR_RX_FLAG, 8'h40);
        irqs(4'b0010);
        rx_err_count <= 9'd128 + 9'($urandom % 128);
        repeat (3) @(posedge clock);
        w(ADDR_RX_FLAG, 8'h50);
        r(ADDR_RX_FLAG, 8'h10);
        tx_err_count <= 9'h12c;
        repeat (3) @(posedge clock);
        r(ADDR_RX_FLAG, 8'h14);
        {rx_err_count, tx_err_count} <= '0;
        repeat (3) @(posedge clock);
        w(ADDR_RX_FLAG, 8'h14);
        r(ADDR_RX_FLAG, 8'h04);
        for (m = 0; m < 128; m++)
        begin
            idle_seq_pulse <= 1'b1;
            @(posedge clock);
            idle_seq_pulse <= 1'b0;
            @(posedge clock);
            if (m == 126)
            begin
                w(ADDR_RX_FLAG, 8'h04);
                r(ADDR_RX_FLAG, 8'h04);
            end
        end
        w(ADDR_RX_FLAG, 8'h04);
        r(ADDR_RX_FLAG, 8'h00);
        tx_err_count <= 9'd96 + 9'($urandom % 32);
        overrun_pulse <= 1'b1;
        {sleep_mode, bus_activity} <= 2'b11;
        @(posedge clock);
        overrun_pulse <= 1'b0;
        {sleep_mode, bus_activity} <= 2'b00;
        repeat (3) @(posedge clock);
        r(ADDR_RX_FLAG, 8'ha2);
        irqs(4'b1010);
        w(ADDR_RX_IRQ_EN, 8'h80);
        irqs(4'b1000);
        tx_err_count <= '0;
        repeat (3) @(posedge clock);
        w(ADDR_RX_FLAG, 8'hff);
        r(ADDR_RX_FLAG, 8'h00);
        w(ADDR_RX_IRQ_EN, 8'h01);
        h1 = 3'($urandom % 8);
        h2 = h1 ^ 3'(1 + $urandom % 7);
        eng_u.deliver(h1);
        r(ADDR_RX_FLAG, 8'h01);
        r(ADDR_FILTER, 8'h10 | 8'(h1));
        irqs(4'b0100);
        fork
            eng_u.deliver(h2);
        join_none
        repeat (8) @(posedge clock);
        r(ADDR_FILTER, 8'h10 | 8'(h1));
        w(ADDR_RX_FLAG, 8'h01);
        repeat (8) @(posedge clock);
        r(ADDR_FILTER, 8'h10 | 8'(h2));
        w(ADDR_RX_FLAG, 8'h01);
        w(ADDR_TX_CTRL, 8'h07);
        irqs(4'b0001);
        w(ADDR_TX_FLAG, 8'h03);
        r(ADDR_TX_FLAG, 8'h04);
        w(ADDR_TX_CTRL, 8'h03);
        irqs(4'b0000);
        tx_in_progress <= 3'h3;
        w(ADDR_TX_CTRL, 8'h13);
        r(ADDR_TX_CTRL, 8'h13);
        tx_in_progress <= 3'h2;
        repeat (3) @(posedge clock);
        r(ADDR_TX_FLAG, 8'h15);
        r(ADDR_TX_CTRL, 8'h03);
        irqs(4'b0001);
        w(ADDR_TX_CTRL, 8'h23);
        w(ADDR_TX_CTRL, 8'h03);
        r(ADDR_TX_CTRL, 8'h23);
        eng_u.sent(1);
        r(ADDR_TX_FLAG, 8'h17);
        r(ADDR_TX_CTRL, 8'h03);
        tx_in_progress <= 3'h0;
        w(ADDR_TX_FLAG, 8'h70);
        r(ADDR_TX_FLAG, 8'h17);
        w(ADDR_TX_FLAG, 8'h01);
        r(ADDR_TX_FLAG, 8'h06);
        w(ADDR_MODULE_CTL, 8'h01);
        r(ADDR_RX_FLAG, 8'h00);
        r(ADDR_RX_IRQ_EN, 8'h00);
        r(ADDR_TX_FLAG, 8'h07);
        r(ADDR_TX_CTRL, 8'h00);
        for (m = 0; m < 4; m++)
        begin
            w(ADDR_FILTER, 8'(m << 4));
            r(ADDR_FILTER, 8'(m << 4) | 8'(h2));
        end
        w(ADDR_MODULE_CTL, 8'h00);
        w(ADDR_FILTER, 8'h10);
        r(ADDR_FILTER, 8'h30 | 8'(h2));
        eng_u.deliver(h1);
        r(ADDR_RX_FLAG, 8'h00);
        r(8'h03, 8'h00);
        close_out();
    end
endmodule
bind csf_status_ctrl csf_status_properties prop_u (.clock, .reset, .rx_msg_ready,
    .tx_sent_pulse, .tx_in_progress, .swap_grant, .abort_request, .filter_mode,
    .soft_reset_ctl, .wakeup_irq, .rx_irq, .err_irq, .tx_irq);
